// [logic/scs_top.sv]
// Switching clock selection, primary clock outputs and soft-start control
`timescale 1ns/1ps

// What this block does
// - In external mode with link B low, invert the link A clock.
// - In external mode with link B high, use link A clock as is.
// - No link A edge for 20 us falls back to internal oscillator.
// - Frequency-set pin floating selects primary mode at fixed 500 kHz.
// - Primary mode drives link A with the switching clock, in phase.
// - Primary mode drives link B at switching rate, 90 degrees later.
// - Regulation reference is the lower of ramp and internal reference.
// - Undervoltage, enable low, high-side limit or thermal discharge ramp.
// - Faults other than high-side limit stop switching, low current state.
// - After shutdown clears, no switching until ramp reaches ground.
// - Feedback above ramp at startup: high side off, low side on.
module scs_top (
  // Clocks and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic link_clk,
  // Straps
  input wire logic freq_set_pin_float,
  input wire logic phase_link_b_in,
  input wire logic [scs_pkg::OSC_W-1:0] osc_half_cyc,
  // Link A pin
  input wire logic phase_link_a_in,
  output logic phase_link_a_out,
  output logic phase_link_a_oe,
  // Link B pin
  output logic phase_link_b_out,
  output logic phase_link_b_oe,
  // Analog status
  input wire scs_pkg::scs_fault_t fault,
  input wire logic [scs_pkg::V_W-1:0] softstart_ramp_pin,
  input wire logic [scs_pkg::V_W-1:0] feedback_voltage,
  // Results
  output logic switching_clock,
  output logic ext_locked,
  output scs_pkg::scs_stage_t stage,
  output logic [scs_pkg::V_W-1:0] reg_reference
);

  // ---------------------------------------------------------------
  // Link domain: sample the incoming clock and make toggle events
  // ---------------------------------------------------------------
  // The link clock may stop; only a toggle crosses, never a level.
  // Reset crosses by two flops; without it the toggle never leaves X
  logic lrst_meta_reg, lrst_reg, lrst_meta_next, lrst_next;
  logic la_meta_reg, la_sync_reg, la_prev_reg, edge_tgl_reg;
  logic la_meta_next, la_sync_next, la_prev_next, edge_tgl_next;

  always_comb begin
    lrst_meta_next = srst;
    lrst_next = lrst_meta_reg;
    la_meta_next = phase_link_a_in;
    la_sync_next = la_meta_reg;
    la_prev_next = la_sync_reg;
    edge_tgl_next = edge_tgl_reg;
    if (la_sync_reg && !la_prev_reg) begin
      edge_tgl_next = !edge_tgl_reg;
    end
  end

  always_ff @(posedge link_clk) begin
    la_meta_reg <= la_meta_next;
    la_sync_reg <= la_sync_next;
    lrst_meta_reg <= lrst_meta_next;
    lrst_reg <= lrst_next;
    la_prev_reg <= la_prev_next;
    if (lrst_reg) begin
      edge_tgl_reg <= 1'b0;
    end else begin
      edge_tgl_reg <= edge_tgl_next;
    end
  end

  // ---------------------------------------------------------------
  // Main domain: straps, toggle crossing and raw input level
  // ---------------------------------------------------------------
  logic [2:0] tg_reg, tg_next;
  logic [1:0] ain_reg, ain_next;
  logic [1:0] bin_reg, bin_next;
  logic [1:0] rt_reg, rt_next;
  logic ext_edge;

  always_comb begin
    tg_next = {tg_reg[1:0], edge_tgl_reg};
    ain_next = {ain_reg[0], phase_link_a_in};
    bin_next = {bin_reg[0], phase_link_b_in};
    rt_next = {rt_reg[0], freq_set_pin_float};
  end

  always_ff @(posedge clk) begin
    tg_reg <= tg_next;
    ain_reg <= ain_next;
    bin_reg <= bin_next;
    rt_reg <= rt_next;
  end

  assign ext_edge = tg_reg[2] ^ tg_reg[1];

  // ---------------------------------------------------------------
  // Mode, loss of clock and source selection
  // ---------------------------------------------------------------
  scs_pkg::scs_mode_t mode_reg, mode_next;
  logic [scs_pkg::TMO_W-1:0] tmo_reg, tmo_next;
  logic use_ext_reg, use_ext_next;
  logic [scs_pkg::OSC_W-1:0] osc_cnt_reg, osc_cnt_next;
  logic osc_reg, osc_next;
  logic [scs_pkg::PH_W-1:0] ph_reg, ph_next;
  logic sw_reg, sw_next;
  logic sw_prev_reg;
  logic lb_reg, lb_next;
  logic ext_clk;
  logic src_clk;
  logic tmo_full;
  logic sw_rise;

  assign tmo_full = tmo_reg == scs_pkg::TMO_W'(scs_pkg::SYNC_TIMEOUT_CYC);
  assign sw_rise = sw_reg && !sw_prev_reg;
  // Inversion select from link B strap
  assign ext_clk = bin_reg[1] ? ain_reg[1] : !ain_reg[1];
  assign src_clk = use_ext_reg ? ext_clk : osc_reg;

  always_comb begin
    mode_next = rt_reg[1] ? scs_pkg::SCS_MODE_PRIMARY
              : scs_pkg::SCS_MODE_EXTERNAL;
    tmo_next = tmo_reg;
    use_ext_next = use_ext_reg;
    osc_cnt_next = osc_cnt_reg + scs_pkg::OSC_W'(1);
    osc_next = osc_reg;
    ph_next = ph_reg;
    sw_next = sw_reg;
    lb_next = lb_reg;
    // Loss-of-clock watchdog
    if (ext_edge) begin
      tmo_next = '0;
    end else if (tmo_reg != scs_pkg::TMO_W'(scs_pkg::SYNC_TIMEOUT_CYC)) begin
      tmo_next = tmo_reg + scs_pkg::TMO_W'(1);
    end
    // Internal oscillator
    if (osc_cnt_reg >= osc_half_cyc - scs_pkg::OSC_W'(1)) begin
      osc_cnt_next = '0;
      osc_next = !osc_reg;
    end
    // Loss falls back at once: a stopped inverted input holds the
    // switching clock high. Return waits for a rising switching edge.
    if (tmo_full) begin
      use_ext_next = 1'b0;
    end else if (sw_rise) begin
      use_ext_next = 1'b1;
    end
    if (mode_reg == scs_pkg::SCS_MODE_PRIMARY) begin
      // Fixed 500 kHz with a quarter period lag on link B
      ph_next = (ph_reg == scs_pkg::PH_LAST) ? '0
              : ph_reg + scs_pkg::PH_W'(1);
      sw_next = ph_reg < scs_pkg::PH_HALF;
      lb_next = (ph_reg >= scs_pkg::PH_QUART)
             && (ph_reg < scs_pkg::PH_3QUART);
      use_ext_next = 1'b0;
    end else begin
      ph_next = '0;
      sw_next = src_clk;
      lb_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= scs_pkg::SCS_MODE_INTERNAL;
      // No edge seen yet, so start on the oscillator
      tmo_reg <= scs_pkg::TMO_W'(scs_pkg::SYNC_TIMEOUT_CYC);
      use_ext_reg <= 1'b0;
      osc_cnt_reg <= '0;
      osc_reg <= 1'b0;
      ph_reg <= '0;
      sw_reg <= 1'b0;
      sw_prev_reg <= 1'b0;
      lb_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      tmo_reg <= tmo_next;
      use_ext_reg <= use_ext_next;
      osc_cnt_reg <= osc_cnt_next;
      osc_reg <= osc_next;
      ph_reg <= ph_next;
      sw_reg <= sw_next;
      sw_prev_reg <= sw_reg;
      lb_reg <= lb_next;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  logic prim_reg, prim_next;
  logic la_o_reg, la_o_next;
  logic lb_o_reg, lb_o_next;

  always_comb begin
    prim_next = mode_reg == scs_pkg::SCS_MODE_PRIMARY;
    la_o_next = sw_next;
    lb_o_next = lb_next;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prim_reg <= 1'b0;
      la_o_reg <= 1'b0;
      lb_o_reg <= 1'b0;
    end else begin
      prim_reg <= prim_next;
      la_o_reg <= la_o_next;
      lb_o_reg <= lb_o_next;
    end
  end

  assign phase_link_a_out = la_o_reg;
  assign phase_link_a_oe = prim_reg;
  assign phase_link_b_out = lb_o_reg;
  assign phase_link_b_oe = prim_reg;
  assign switching_clock = sw_reg;
  assign ext_locked = use_ext_reg;

  // ---------------------------------------------------------------
  // Soft-start sequencing
  // ---------------------------------------------------------------
  // Analog comparisons are taken as same-domain inputs from the
  // front-end model; faults other than high-side limit are latched so restart waits for ground.
  logic hold_reg, hold_next;
  scs_pkg::scs_stage_t stage_reg, stage_next;
  logic [scs_pkg::V_W-1:0] ref_reg, ref_next;
  logic shut;

  assign shut = fault.input_undervoltage_lockout || fault.enable_low || fault.thermal;

  always_comb begin
    hold_next = hold_reg;
    if (shut) begin
      hold_next = 1'b1;
    end else if (softstart_ramp_pin == scs_pkg::RAMP_ZERO) begin
      hold_next = 1'b0;
    end
    ref_next = (softstart_ramp_pin < scs_pkg::VREF_CODE)
             ? softstart_ramp_pin : scs_pkg::VREF_CODE;
    stage_next.discharge = shut || fault.hs_current_limit;
    stage_next.low_current = shut || hold_reg;
    if (shut || hold_reg) begin
      stage_next.hs_on = 1'b0;
      stage_next.ls_on = 1'b0;
    end else if (feedback_voltage > softstart_ramp_pin) begin
      stage_next.hs_on = 1'b0;
      stage_next.ls_on = 1'b1;
    end else begin
      stage_next.hs_on = sw_reg;
      stage_next.ls_on = !sw_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_reg <= 1'b1;
      stage_reg <= '0;
      ref_reg <= '0;
    end else begin
      hold_reg <= hold_next;
      stage_reg <= stage_next;
      ref_reg <= ref_next;
    end
  end

  assign stage = stage_reg;
  assign reg_reference = ref_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_invert;
    @(posedge clk) disable iff (srst)
      (mode_reg == scs_pkg::SCS_MODE_EXTERNAL && use_ext_reg && !bin_reg[1]
       && $stable(bin_reg[1])) |=> (sw_reg == !$past(ain_reg[1]));
  endproperty
  a_invert: assert property (p_invert) else $error("inversion wrong");

  property p_noinv;
    @(posedge clk) disable iff (srst)
      (mode_reg == scs_pkg::SCS_MODE_EXTERNAL && use_ext_reg && bin_reg[1]
       && $stable(bin_reg[1])) |=> (sw_reg == $past(ain_reg[1]));
  endproperty
  a_noinv: assert property (p_noinv) else $error("pass-through wrong");

  property p_fallback;
    @(posedge clk) disable iff (srst)
      (tmo_reg == scs_pkg::TMO_W'(scs_pkg::SYNC_TIMEOUT_CYC) && !ext_edge)
      |-> ##[1:200] !use_ext_reg;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fallback");

  property p_prim_period;
    @(posedge clk) disable iff (srst)
      (prim_reg && $past(prim_reg) && $rose(sw_reg))
      |-> ##40 $fell(sw_reg);
  endproperty
  a_prim_period: assert property (p_prim_period)
    else $error("primary half period wrong");

  property p_link_a;
    @(posedge clk) disable iff (srst)
      prim_reg |-> (phase_link_a_out == sw_reg && phase_link_a_oe);
  endproperty
  a_link_a: assert property (p_link_a) else $error("link A not in phase");

  property p_link_b;
    @(posedge clk) disable iff (srst)
      (prim_reg && $past(prim_reg, 2) && $rose(sw_reg))
      |-> ##20 $rose(phase_link_b_out);
  endproperty
  a_link_b: assert property (p_link_b) else $error("link B not lagging");

  property p_ref;
    @(posedge clk) disable iff (srst)
      ##1 (reg_reference <= scs_pkg::VREF_CODE
           && reg_reference <= $past(softstart_ramp_pin)
           && (reg_reference == scs_pkg::VREF_CODE
               || reg_reference == $past(softstart_ramp_pin)));
  endproperty
  a_ref: assert property (p_ref) else $error("reference too high");

  property p_discharge;
    @(posedge clk) disable iff (srst)
      fault.hs_current_limit |=> stage.discharge;
  endproperty
  a_discharge: assert property (p_discharge) else $error("no discharge");

  property p_stop;
    @(posedge clk) disable iff (srst)
      shut |=> (!stage.hs_on && !stage.ls_on && stage.low_current);
  endproperty
  a_stop: assert property (p_stop) else $error("still switching");

  property p_restart;
    @(posedge clk) disable iff (srst)
      (hold_reg && softstart_ramp_pin != scs_pkg::RAMP_ZERO) |=> hold_reg;
  endproperty
  a_restart: assert property (p_restart) else $error("early restart");

  property p_skip;
    @(posedge clk) disable iff (srst)
      (!shut && !hold_reg && feedback_voltage > softstart_ramp_pin)
      |=> (!stage.hs_on && stage.ls_on);
  endproperty
  a_skip: assert property (p_skip) else $error("no pulse skip");

  property p_return;
    @(posedge clk) disable iff (srst)
      $rose(use_ext_reg) |-> $past(sw_rise);
  endproperty
  a_return: assert property (p_return) else $error("switch off boundary");

  c_fallback: cover property (@(posedge clk) disable iff (srst)
    $fell(use_ext_reg));
  c_return: cover property (@(posedge clk) disable iff (srst)
    $rose(use_ext_reg));
  c_primary: cover property (@(posedge clk) disable iff (srst)
    prim_reg && $rose(phase_link_b_out));
  c_skip: cover property (@(posedge clk) disable iff (srst)
    stage.ls_on && !stage.hs_on && !hold_reg);

endmodule

// [logic/scs_pkg.sv]
// Package: constants and types for the switching clock and soft-start block
package scs_pkg;

  // Clock rate of the main domain
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_PS = 25_000;

  // Loss-of-clock timeout, 20 us, rounded down to whole cycles
  localparam int SYNC_TIMEOUT_NS = 20_000;
  localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_NS * 1000 / CLK_PERIOD_PS;
  localparam int TMO_W = 11;

  // Primary mode clock, 500 kHz: 80 cycles a period at 40 MHz
  localparam int PRIMARY_HZ = 500_000;
  localparam int PRIMARY_CYC = CLK_HZ / PRIMARY_HZ;
  localparam int PH_W = 7;
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(PRIMARY_CYC - 1);
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(PRIMARY_CYC / 2);
  localparam logic [PH_W-1:0] PH_QUART = PH_W'(PRIMARY_CYC / 4);
  localparam logic [PH_W-1:0] PH_3QUART = PH_W'(3 * PRIMARY_CYC / 4);

  // Internal oscillator half period in cycles, set by the resistor value
  localparam int OSC_W = 12;
  localparam logic [OSC_W-1:0] OSC_HALF_DEF = 12'h028;

  // Analog levels are carried as unsigned codes
  localparam int V_W = 12;
  localparam logic [V_W-1:0] VREF_CODE = 12'h25C;
  localparam logic [V_W-1:0] RAMP_ZERO = 12'h000;

  // Switching clock source
  typedef enum logic [1:0] {
    SCS_MODE_INTERNAL,
    SCS_MODE_EXTERNAL,
    SCS_MODE_PRIMARY
  } scs_mode_t;

  // Fault inputs that discharge the ramp
  typedef struct packed {
    logic input_undervoltage_lockout;
    logic enable_low;
    logic hs_current_limit;
    logic thermal;
  } scs_fault_t;

  // Power stage commands
  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic discharge;
    logic low_current;
  } scs_stage_t;

endpackage

// [testbench/scs_ext_src.sv]
// External sync clock source model that drives the link A pin
`timescale 1ns/1ps

module scs_ext_src (
  // Control
  input wire logic run,
  input wire logic [15:0] half_ns,
  // Clock out
  output logic clk_out
);
  // ----------------------------------------
  // Source
  // ----------------------------------------
  // Stops at the end of the current half, then stands still low
  always begin
    if (run) begin
      #(half_ns);
      clk_out = run ? ~clk_out : 1'h0;
    end else begin
      clk_out = 1'h0;
      @(run);
    end
  end
endmodule

// [testbench/scs_top_tb.sv]
// Self-checking bench for the switching clock and soft-start block
`timescale 1ns/1ps

module scs_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'h0;
  logic link_clk = 1'h0;
  logic srst = 1'h1;
  logic rt_float = 1'h0;
  logic link_b = 1'h0;
  logic [11:0] osc_half = 12'h028;
  logic src_run = 1'h0;
  logic [15:0] src_half = 16'h03E8;
  logic src_clk;
  scs_pkg::scs_fault_t fault = '0;
  logic [11:0] ramp = 12'h000;
  logic [11:0] fb = 12'h000;
  logic a_out, a_oe, b_out, b_oe, sw, locked;
  scs_pkg::scs_stage_t stage;
  logic [11:0] ref_v;
  wire logic a_wire = a_oe ? a_out : src_clk;
  int fail_count = 0;
  int checked = 0;
  int i, k, n;
  logic [11:0] r, f;

  always #12.5 clk = ~clk;
  initial begin
    // Phase offset keeps the link clock unrelated to the main clock
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  scs_ext_src u_scs_ext_src (.run(src_run), .half_ns(src_half),
    .clk_out(src_clk));

  scs_top u_scs_top (.clk(clk), .srst(srst), .link_clk(link_clk),
    .freq_set_pin_float(rt_float), .phase_link_b_in(link_b),
    .osc_half_cyc(osc_half), .phase_link_a_in(a_wire),
    .phase_link_a_out(a_out), .phase_link_a_oe(a_oe),
    .phase_link_b_out(b_out), .phase_link_b_oe(b_oe), .fault(fault),
    .softstart_ramp_pin(ramp), .feedback_voltage(fb),
    .switching_clock(sw), .ext_locked(locked), .stage(stage),
    .reg_reference(ref_v));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [11:0] exp_ref(input logic [11:0] v);
    return (v < scs_pkg::VREF_CODE) ? v : scs_pkg::VREF_CODE;
  endfunction

  task automatic chk1(input string what, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chkv(input string what, input logic [11:0] e,
    input logic [11:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wait_lock(input int lim);
    for (n = 0; n < lim && locked !== 1'h1; n++) @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Expected run is under 100 us; leave a wide margin
  initial begin
    #500000;
    fail_count++;
    final_report();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(90));
    repeat (12) @(posedge clk);
    #1;
    chk1("link_a_oe", 1'h0, a_oe);
    chk1("link_b_oe", 1'h0, b_oe);
    @(posedge clk);
    srst <= 1'h0;
    repeat (4) @(posedge clk);
    // Reference and pulse skipping, random with boundary values
    for (i = 0; i < 40; i++) begin
      r = 12'($urandom_range(1, 4095));
      f = (i == 2) ? r : 12'($urandom_range(0, 4095));
      if (i < 2) r = scs_pkg::VREF_CODE + 12'(i);
      @(posedge clk);
      ramp <= r;
      fb <= f;
      @(posedge clk);
      #1;
      chkv("reg_reference", exp_ref(r), ref_v);
      if (f > r) begin
        chk1("hs_on", 1'h0, stage.hs_on);
        chk1("ls_on", 1'h1, stage.ls_on);
      end
      chk1("low_current", 1'h0, stage.low_current);
    end
    // Each discharge event, then the restart hold
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      fault <= scs_pkg::scs_fault_t'(4'h8 >> k);
      ramp <= 12'h100;
      @(posedge clk);
      #1;
      chk1("discharge", 1'h1, stage.discharge);
      chk1("low_current", k != 2, stage.low_current);
      if (k != 2) chk1("hs_on", 1'h0, stage.hs_on);
      @(posedge clk);
      fault <= '0;
      repeat (6) @(posedge clk);
      #1;
      if (k != 2) chk1("hold", 1'h1, stage.low_current);
      @(posedge clk);
      ramp <= 12'h000;
      repeat (4) @(posedge clk);
      #1;
      chk1("restart", 1'h0, stage.low_current);
    end
    // External sync at 500 kHz, both link B straps
    src_run = 1'h1;
    wait_lock(3000);
    chk1("ext_locked", 1'h1, locked);
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      link_b <= k[0];
      repeat (10) @(posedge clk);
      for (i = 0; i < 4; i++) begin
        @(posedge src_clk);
        #407.3;
        if (k == 0) chk1("sw_inverted", 1'h0, sw);
        else chk1("sw_direct", 1'h1, sw);
      end
    end
    // Loss of clock, fallback to the oscillator, then return
    @(posedge clk);
    osc_half <= 12'($urandom_range(20, 60));
    @(negedge src_clk);
    src_run = 1'h0;
    repeat (700) @(posedge clk);
    #1;
    chk1("no_early_fallback", 1'h1, locked);
    for (n = 0; n < 260 && locked !== 1'h0; n++) @(posedge clk);
    #1;
    chk1("fallback", 1'h0, locked);
    // The first high after the switch may be cut short
    @(posedge sw);
    @(posedge sw);
    #1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sw === 1'h1 && n < 200);
    chkv("osc_half", osc_half, 12'(n));
    src_run = 1'h1;
    wait_lock(2000);
    chk1("relock", 1'h1, locked);
    // Primary mode: 500 kHz out on link A, 90 degrees later on link B
    src_run = 1'h0;
    @(posedge clk);
    rt_float <= 1'h1;
    for (n = 0; n < 20 && a_oe !== 1'h1; n++) @(posedge clk);
    #1;
    chk1("link_a_oe", 1'h1, a_oe);
    chk1("link_b_oe", 1'h1, b_oe);
    @(posedge sw);
    #1;
    for (i = 0; i < scs_pkg::PRIMARY_CYC; i++) begin
      chk1("sw_primary", i < scs_pkg::PRIMARY_CYC / 2, sw);
      chk1("link_a_out", i < scs_pkg::PRIMARY_CYC / 2, a_out);
      chk1("link_b_out", i >= scs_pkg::PRIMARY_CYC / 4 &&
        i < 3 * scs_pkg::PRIMARY_CYC / 4, b_out);
      @(posedge clk);
      #1;
    end
    final_report();
  end
endmodule
